// [logic/tmr8_pkg.sv]
// Shared constants and types for the 8-bit event/capture timer
package tmr8_pkg;
  // Register bus geometry
  localparam int          ADDR_W          = 5;
  localparam logic [4:0]  OFS_CTRL        = 5'h00;
  localparam logic [4:0]  OFS_REG_A       = 5'h04;
  localparam logic [4:0]  OFS_REG_B       = 5'h08;
  localparam logic [4:0]  OFS_EXT_CTRL    = 5'h0C;
  localparam logic [4:0]  OFS_IRQ_STAT    = 5'h10;
  localparam logic [4:0]  OFS_IRQ_MASK    = 5'h14;
  localparam logic [4:0]  OFS_COUNT       = 5'h18;
  // Control register fields
  localparam int          CTRL_START      = 0;
  localparam int          CTRL_MODE_LO    = 1;
  localparam int          CTRL_CLK_LO     = 3;
  localparam int          CTRL_SLOW_PRE   = 5;
  localparam int          CTRL_SOFT_CAP   = 6;
  localparam int          CTRL_SLOW_MODE  = 7;
  // External interrupt control field
  localparam int          EXT_EDGE_SEL    = 3;
  // Interrupt status field
  localparam int          STAT_TIMER      = 0;
  // Reset values
  localparam logic [7:0]  CTRL_RST        = 8'h00;
  localparam logic [7:0]  EXT_RST         = 8'h00;
  localparam logic [7:0]  MASK_RST        = 8'h00;
  localparam logic [7:0]  STAT_RST        = 8'h00;
  localparam logic [7:0]  COUNT_RST       = 8'h00;
  // Prescaler exponents
  localparam int          FC_DIV_W        = 12;
  localparam int          FC_EXP_0        = 12;
  localparam int          FC_EXP_1        = 10;
  localparam int          FC_EXP_2        = 7;
  localparam int          FS_DIV_W        = 4;
  localparam int          FS_EXP_0        = 4;
  localparam int          FS_EXP_1        = 2;
  // Capture overflow marker
  localparam logic [7:0]  CNT_OVF         = 8'hFF;
  // Bus responses
  localparam logic [1:0]  RESP_OKAY       = 2'h0;
  localparam logic [1:0]  RESP_SLVERR     = 2'h2;
  // Operating modes
  typedef enum logic [1:0] {
    TMR8_TIMER,
    TMR8_EVENT,
    TMR8_CAPTURE,
    TMR8_RSVD
  } tmr8_mode_t;
endpackage : tmr8_pkg

// [logic/tmr8_if.sv]
// Carrier between the timer top and its tick/edge generator
`timescale 1ns/1ps
interface tmr8_if;
  logic [1:0] clk_sel;   // Internal clock choice
  logic       slow_pre;  // Low-frequency prescale option
  logic       slow_mode; // Slow or sleep operation
  logic       edge_sel;  // Active edge, 1 = falling
  logic       tick;      // Internal count pulse
  logic       act_edge;  // Active-polarity pin edge
  logic       opp_edge;  // Opposite-polarity pin edge
  modport ctl (output clk_sel, slow_pre, slow_mode, edge_sel, input tick, act_edge, opp_edge);
  modport gen (input clk_sel, slow_pre, slow_mode, edge_sel, output tick, act_edge, opp_edge);
endinterface : tmr8_if

// [logic/tmr8_tick.sv]
// Prescaler and timer input edge detector
`timescale 1ns/1ps
module tmr8_tick
  import tmr8_pkg::*;
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst_n,
  // Pins
  input  wire logic low_freq_clock,
  input  wire logic timer_input_pin,
  // Carrier
  tmr8_if.gen       tb
);
  typedef struct packed {
    logic [FC_DIV_W-1:0] fc_div; // Free divider of mclk
    logic                fs_q;   // Last low-frequency level
    logic [FS_DIV_W-1:0] fs_div; // Divider of low-frequency edges
    logic                pin_s1; // Synchroniser, first stage
    logic                pin_s2; // Synchroniser, second stage
    logic                pin_s3; // Edge detect history
    logic                tick;
    logic                act;
    logic                opp;
  } tmr8_tick_t;

  tmr8_tick_t s;
  tmr8_tick_t next_s;

  // True when the low n bits are all ones
  function automatic logic low_ones(input logic [FC_DIV_W-1:0] v, input int n);
    logic r;
    r = 1'b1;
    for (int i = 0; i < FC_DIV_W; i++) begin
      if (i < n && !v[i]) r = 1'b0;
    end
    return r;
  endfunction : low_ones

  ////////////////////////////////////////////////////////////////
  // Next state: dividers, clock choice, pin edges
  always_comb begin
    logic fs_rise;
    logic [FC_DIV_W-1:0] fs_ext;
    logic rise;
    logic fall;
    next_s = s;
    fs_rise = low_freq_clock & ~s.fs_q;
    fs_ext = {{(FC_DIV_W-FS_DIV_W){1'b0}}, s.fs_div};
    rise = s.pin_s2 & ~s.pin_s3;
    fall = ~s.pin_s2 & s.pin_s3;
    next_s.fs_q = low_freq_clock;
    next_s.fc_div = FC_DIV_W'(s.fc_div + 1'b1);
    if (fs_rise) next_s.fs_div = FS_DIV_W'(s.fs_div + 1'b1);
    // Slow modes allow only the low-frequency clock over 16
    if (tb.slow_mode) begin
      next_s.tick = fs_rise & low_ones(fs_ext, FS_EXP_0);
    end else if (tb.slow_pre) begin
      case (tb.clk_sel)
        2'h0:    next_s.tick = fs_rise & low_ones(fs_ext, FS_EXP_0);
        2'h1:    next_s.tick = fs_rise & low_ones(fs_ext, FS_EXP_1);
        default: next_s.tick = low_ones(s.fc_div, FC_EXP_2);
      endcase
    end else begin
      case (tb.clk_sel)
        2'h0:    next_s.tick = low_ones(s.fc_div, FC_EXP_0);
        2'h1:    next_s.tick = low_ones(s.fc_div, FC_EXP_1);
        default: next_s.tick = low_ones(s.fc_div, FC_EXP_2);
      endcase
    end
    // Two-stage synchroniser, edges seen past the second stage
    next_s.pin_s1 = timer_input_pin;
    next_s.pin_s2 = s.pin_s1;
    next_s.pin_s3 = s.pin_s2;
    // Edge polarity chosen by the edge select bit
    next_s.act = tb.edge_sel ? fall : rise;
    next_s.opp = tb.edge_sel ? rise : fall;
  end

  // State register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) s <= '0;
    else s <= next_s;
  end

  assign tb.tick     = s.tick;
  assign tb.act_edge = s.act;
  assign tb.opp_edge = s.opp;
endmodule : tmr8_tick

// [logic/tmr8_top.sv]
// 8-bit timer, event counter and input capture with AXI4-Lite registers
`timescale 1ns/1ps
module tmr8_top
  import tmr8_pkg::*;
(
  // Clock and reset
  input  wire logic              mclk,
  input  wire logic              rst_n,
  // AXI4-Lite write address
  input  wire logic              s_axi_awvalid,
  output wire logic              s_axi_awready,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic              s_axi_wvalid,
  output wire logic              s_axi_wready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  // AXI4-Lite write response
  output wire logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  output wire logic [1:0]        s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic              s_axi_arvalid,
  output wire logic              s_axi_arready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  // AXI4-Lite read data
  output wire logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output wire logic [31:0]       s_axi_rdata,
  output wire logic [1:0]        s_axi_rresp,
  // Pins
  input  wire logic              low_freq_clock,
  input  wire logic              timer_input_pin,
  // Interrupt
  output wire logic              timer_irq
);

  ////////////////////////////////////////////////////////////////
  // State types

  // Control, bus and counter state initialised by the synchronised reset
  typedef struct packed {
    logic              aw_have; // Write address held
    logic [ADDR_W-1:0] aw_addr;
    logic              w_have;  // Write data held
    logic [31:0]       w_data;
    logic [3:0]        w_strb;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    logic [7:0]        ctrl;    // timer_ctrl_reg
    logic [7:0]        ext;     // ext_int_control_reg
    logic [7:0]        mask;    // Interrupt mask
    logic [7:0]        stat;    // Sticky interrupt status
    logic [7:0]        cnt;     // Up-counter
    logic              armed;   // Capture and overflow enabled
  } tmr8_state_t;

  tmr8_state_t s;
  tmr8_state_t next_s;

  // Data registers kept outside the reset struct
  logic [7:0] compare_capture_reg_a;
  logic [7:0] capture_reg_b;
  logic [7:0] next_a;
  logic [7:0] next_b;

  // Synchronised reset
  logic [1:0] rst_pipe;
  logic       rst_n_sync;

  // Carrier to the tick generator
  tmr8_if tif ();

  ////////////////////////////////////////////////////////////////
  // Helpers

  // Word-aligned address compare, lane bits ignored
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
    return a[ADDR_W-1:2] == ofs[ADDR_W-1:2];
  endfunction : hit

  // True for any mapped register
  function automatic logic mapped(input logic [ADDR_W-1:0] a);
    return hit(a, OFS_CTRL) | hit(a, OFS_REG_A) | hit(a, OFS_REG_B) |
           hit(a, OFS_EXT_CTRL) | hit(a, OFS_IRQ_STAT) | hit(a, OFS_IRQ_MASK) |
           hit(a, OFS_COUNT);
  endfunction : mapped

  ////////////////////////////////////////////////////////////////
  // Reset release through two flops

  // Assertion is immediate, release waits two edges
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      rst_pipe <= 2'h0;
    end else begin
      rst_pipe <= {rst_pipe[0], 1'b1};
    end
  end
  assign rst_n_sync = rst_pipe[1];

  ////////////////////////////////////////////////////////////////
  // Tick and edge generator

  assign tif.clk_sel   = s.ctrl[CTRL_CLK_LO +: 2];
  assign tif.slow_pre  = s.ctrl[CTRL_SLOW_PRE];
  assign tif.slow_mode = s.ctrl[CTRL_SLOW_MODE];
  assign tif.edge_sel  = s.ext[EXT_EDGE_SEL];

  tmr8_tick u_tick (
    .mclk            (mclk),
    .rst_n           (rst_n_sync),
    .low_freq_clock  (low_freq_clock),
    .timer_input_pin (timer_input_pin),
    .tb              (tif.gen)
  );

  ////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    logic       do_wr;     // Address and data both held
    logic       wr_lane;   // Low byte lane enabled
    logic       ar_fire;   // Read address taken
    logic       ev;        // Timer interrupt event
    logic       soft_cap;  // Soft capture requested
    logic [7:0] wb;        // Write byte
    logic [7:0] w1c;       // Status bits being cleared
    logic [7:0] rd;        // Read mux
    tmr8_mode_t mode;
    next_s   = s;
    next_a   = compare_capture_reg_a;
    next_b   = capture_reg_b;
    do_wr    = s.aw_have & s.w_have & ~s.bvalid;
    wr_lane  = s.w_strb[0];
    ar_fire  = s_axi_arvalid & ~s.rvalid;
    ev       = 1'b0;
    soft_cap = 1'b0;
    wb       = s.w_data[7:0];
    w1c      = 8'h00;
    rd       = 8'h00;
    mode     = tmr8_mode_t'(s.ctrl[CTRL_MODE_LO +: 2]);

    // Write channels are taken in either order
    if (s_axi_awvalid && !s.aw_have && !s.bvalid) begin
      next_s.aw_have = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !s.w_have && !s.bvalid) begin
      next_s.w_have = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    // Response retires on bready
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end

    // Register write once both halves are held
    if (do_wr) begin
      next_s.aw_have = 1'b0;
      next_s.w_have  = 1'b0;
      next_s.bvalid  = 1'b1;
      next_s.bresp   = mapped(s.aw_addr) ? RESP_OKAY : RESP_SLVERR;
      if (wr_lane) begin
        if (hit(s.aw_addr, OFS_CTRL)) begin
          // Request bit is never stored, so it reads back as zero
          next_s.ctrl = wb & ~(8'h01 << CTRL_SOFT_CAP);
          soft_cap    = wb[CTRL_SOFT_CAP];
        end
        if (hit(s.aw_addr, OFS_REG_A)) begin
          next_a = wb;
        end
        if (hit(s.aw_addr, OFS_EXT_CTRL)) begin
          next_s.ext = wb;
        end
        if (hit(s.aw_addr, OFS_IRQ_MASK)) begin
          next_s.mask = wb;
        end
        if (hit(s.aw_addr, OFS_IRQ_STAT)) begin
          w1c = wb;
        end
      end
    end

    // Read mux, register B and count are read-only
    if (hit(s_axi_araddr, OFS_CTRL))          rd = s.ctrl;
    else if (hit(s_axi_araddr, OFS_REG_A))    rd = compare_capture_reg_a;
    else if (hit(s_axi_araddr, OFS_REG_B))    rd = capture_reg_b;
    else if (hit(s_axi_araddr, OFS_EXT_CTRL)) rd = s.ext;
    else if (hit(s_axi_araddr, OFS_IRQ_STAT)) rd = s.stat;
    else if (hit(s_axi_araddr, OFS_IRQ_MASK)) rd = s.mask;
    else if (hit(s_axi_araddr, OFS_COUNT))    rd = s.cnt;
    else                                      rd = 8'h00;

    // Read answer one edge after the address is taken
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    if (ar_fire) begin
      next_s.rvalid = 1'b1;
      next_s.rdata  = {24'h000000, rd};
      next_s.rresp  = mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      // Reading A re-arms capture; a capture in this same cycle still wins
      if (hit(s_axi_araddr, OFS_REG_A)) begin
        next_s.armed = 1'b1;
      end
    end

    // Counter engine, uses the current control value
    if (!s.ctrl[CTRL_START]) begin
      // Stopped: counter held at zero, capture ready
      next_s.cnt   = COUNT_RST;
      next_s.armed = 1'b1;
    end else begin
      case (mode) // Three modes, the fourth code only holds
        TMR8_TIMER: begin
          // Internal clock counting with compare on A
          if (tif.tick) begin
            if (s.cnt == compare_capture_reg_a) begin
              next_s.cnt = COUNT_RST;
              ev         = 1'b1;
            end else begin
              next_s.cnt = 8'(s.cnt + 1'b1);
            end
          end
          // Soft capture of the live count
          if (soft_cap) next_b = s.cnt;
        end
        TMR8_EVENT: begin
          // Pin edges advance the counter
          if (tif.act_edge) begin
            if (s.cnt == compare_capture_reg_a) begin
              next_s.cnt = COUNT_RST;
              ev         = 1'b1;
            end else begin
              next_s.cnt = 8'(s.cnt + 1'b1);
            end
          end
          // Soft capture works here as well
          if (soft_cap) next_b = s.cnt;
        end
        TMR8_CAPTURE: begin
          // Free run on the internal clock; wraps through zero
          if (tif.tick) begin
            next_s.cnt = 8'(s.cnt + 1'b1);
          end
          if (tif.act_edge && s.armed) begin
            // Period capture clears the counter
            next_a       = s.cnt;
            next_s.cnt   = COUNT_RST;
            ev           = 1'b1;
            next_s.armed = 1'b0;
          end else if (tif.tick && s.cnt == CNT_OVF && s.armed) begin
            // Overflow marker in A
            next_a       = CNT_OVF;
            ev           = 1'b1;
            next_s.armed = 1'b0;
          end
          // Width capture, count carries on
          if (tif.opp_edge && s.armed) begin
            next_b = s.cnt;
          end
        end
        default: begin
          // Reserved mode code holds the counter
          next_s.cnt = s.cnt;
        end
      endcase
    end

    // Sticky status, a new event beats a clear in the same cycle
    next_s.stat = (s.stat & ~w1c) | {7'h00, ev};
  end

  ////////////////////////////////////////////////////////////////
  // Registers

  // Control and bus state, initialised by reset
  always_ff @(posedge mclk or negedge rst_n_sync) begin
    if (!rst_n_sync) begin
      s       <= '0;
      s.ctrl  <= CTRL_RST;
      s.ext   <= EXT_RST;
      s.mask  <= MASK_RST;
      s.stat  <= STAT_RST;
      s.cnt   <= COUNT_RST;
      s.armed <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  // Registers A and B carry no reset, contents survive it
  always_ff @(posedge mclk) begin
    compare_capture_reg_a <= next_a;
    capture_reg_b         <= next_b;
  end

  ////////////////////////////////////////////////////////////////
  // Outputs

  // Ready only while the channel's holding slot is free
  assign s_axi_awready = ~s.aw_have & ~s.bvalid;
  assign s_axi_wready  = ~s.w_have & ~s.bvalid;
  assign s_axi_bvalid  = s.bvalid;
  assign s_axi_bresp   = s.bresp;
  assign s_axi_arready = ~s.rvalid;
  assign s_axi_rvalid  = s.rvalid;
  assign s_axi_rdata   = s.rdata;
  assign s_axi_rresp   = s.rresp;

  // Level interrupt from unmasked sticky bits
  assign timer_irq = |(s.stat & s.mask);

endmodule : tmr8_top

// [bench/tmr8_checker.sv]
// Bus and register-view assertions for the 8-bit event/capture timer
`timescale 1ns/1ps
module tmr8_checker
  import tmr8_pkg::*;
(
  // Clock and reset
  input wire logic              mclk,
  input wire logic              rst_n,
  // Write side
  input wire logic              s_axi_awvalid,
  input wire logic              s_axi_awready,
  input wire logic              s_axi_wvalid,
  input wire logic              s_axi_wready,
  input wire logic              s_axi_bvalid,
  input wire logic              s_axi_bready,
  input wire logic [1:0]        s_axi_bresp,
  // Read side
  input wire logic              s_axi_arvalid,
  input wire logic              s_axi_arready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic              s_axi_rvalid,
  input wire logic              s_axi_rready,
  input wire logic [31:0]       s_axi_rdata,
  input wire logic [1:0]        s_axi_rresp
);
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////////////////////////////
  // Handshake steps
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  ////////////////////////////////////////////////////////////////
  // Answers stand until taken
  a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write answer dropped early");
  a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer changed early");
  // Refusals while an answer is pending
  a_busy_refuse: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answer pending");
  a_read_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answer pending");
  // Answer latency
  a_write_answer: assert property (s_wr_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  a_read_answer: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read answer late");
  // Register contents are one byte wide
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits set");
  // Unmapped slot answers with an error and zero
  a_unmapped_err: assert property (s_rd_taken ##0 (s_axi_araddr == 5'h1C)
    |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  // Soft capture request never reads back as set
  a_soft_cap_zero: assert property (s_rd_taken ##0 (s_axi_araddr == OFS_CTRL)
    |=> !s_axi_rdata[CTRL_SOFT_CAP])
    else $error("soft capture bit stuck");
endmodule : tmr8_checker

bind tmr8_top tmr8_checker tmr8_checker_inst (
  .mclk(mclk), .rst_n(rst_n),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp));

// [bench/tmr8_src.sv]
// Pulse source model for the timer input pin and the slow clock
`timescale 1ns/1ps
module tmr8_src (
  // Clock
  input  wire logic mclk,
  // Pins toward the timer
  output logic      low_freq_clock,
  output logic      timer_input_pin
);
  // Slow clock half period in fast cycles
  localparam int FS_HALF = 4;
  int fs_cnt = 0;
  initial begin
    low_freq_clock  = 1'b0;
    timer_input_pin = 1'b0;
  end
  // Slow oscillator runs freely, like a watch crystal
  always @(posedge mclk) begin
    fs_cnt <= (fs_cnt == FS_HALF - 1) ? 0 : fs_cnt + 1;
    if (fs_cnt == FS_HALF - 1) low_freq_clock <= ~low_freq_clock;
  end
  // Hold a level at least 8 cycles, so pulses never outrun the counter
  task automatic level(input logic v, input int n);
    @(posedge mclk);
    timer_input_pin <= v;
    repeat ((n < 8 ? 8 : n) - 1) @(posedge mclk);
  endtask : level
  // One high phase followed by one low phase
  task automatic pulse(input int hi, input int lo);
    level(1'b1, hi);
    level(1'b0, lo);
  endtask : pulse
endmodule : tmr8_src

// [bench/tmr8_top_tb.sv]
// Self-checking bench for the 8-bit event/capture timer
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module tmr8_top_tb
  import tmr8_pkg::*;
;
  // Expected answer: response, value and compare mask
  typedef struct packed {logic [1:0] r; logic [31:0] v; logic [31:0] m;} tmr8_exp_t;
  localparam logic [4:0] RST_OFS [5] = '{OFS_CTRL, OFS_EXT_CTRL, OFS_IRQ_STAT, OFS_IRQ_MASK, OFS_COUNT};
  // Timer configs and their periods with compare value 1
  localparam logic [7:0] TCFG [7] = '{8'h01, 8'h09, 8'h11, 8'h21, 8'h29, 8'h81, 8'h19};
  localparam logic [31:0] TPER [7] = '{32'h2000, 32'h800, 32'h100, 32'h100, 32'h40, 32'h100, 32'h100};
  logic              mclk = 1'b0;
  logic              rst_n = 1'b0;
  logic              awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [ADDR_W-1:0] awaddr = 5'h00, araddr = 5'h00;
  logic [31:0]       wdata = 32'h0, cyc = 32'h0, t1, t2, n;
  logic [15:0]       lfsr = 16'h7225;
  wire               awready, wready, bvalid, arready, rvalid, timer_irq, lfc, pin;
  wire [1:0]         bresp, rresp;
  wire [31:0]        rdata;
  tmr8_exp_t         exp_q[$];
  tmr8_exp_t         e_now;
  int                num_errors = 0;
  int                n_compared = 0;
  ////////////////////////////////////////////////////////////////
  tmr8_top tmr8_top_inst (
    .mclk(mclk), .rst_n(rst_n),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_bresp(bresp),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .low_freq_clock(lfc), .timer_input_pin(pin), .timer_irq(timer_irq));
  tmr8_src tmr8_src_inst (.mclk(mclk), .low_freq_clock(lfc), .timer_input_pin(pin));
  ////////////////////////////////////////////////////////////////
  // Clock and cycle count
  always #25 mclk = ~mclk;
  always @(posedge mclk) cyc <= cyc + 32'h1;
  // Pseudo-random steps
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next
  // Watcher: each bus answer is compared with the oldest note
  always @(posedge mclk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      e_now = exp_q.pop_front();
      `CHK(bvalid ? bresp : rresp, e_now.r)
      `CHK(bvalid ? 32'h0 : (rdata & e_now.m), e_now.v & e_now.m)
    end
  end
  // Bus write; a stuck handshake counts as a mismatch
  task automatic wr(input logic [4:0] a, input logic [31:0] d, input logic [1:0] r = RESP_OKAY);
    int k;
    exp_q.push_back('{r, 32'h0, 32'h0});
    @(posedge mclk);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (k == 50) num_errors++;
  endtask : wr
  // Bus read with expected value under a mask
  task automatic rd(input logic [4:0] a, input logic [31:0] v, input logic [31:0] m = 32'hFFFFFFFF,
                    input logic [1:0] r = RESP_OKAY);
    int k;
    exp_q.push_back('{r, v, m});
    @(posedge mclk);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (k == 50) num_errors++;
  endtask : rd
  // Wait for the interrupt line, bounded
  task automatic wait_irq(output logic [31:0] t);
    int k;
    for (k = 0; k < 20000 && timer_irq !== 1'b1; k++) @(posedge mclk);
    t = cyc;
    if (k == 20000) num_errors++;
  endtask : wait_irq
  // Verdict and end of run
  task automatic close_out();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : close_out
  // Watchdog well beyond the expected run of about 35000 cycles
  initial begin
    repeat (90000) @(posedge mclk);
    num_errors++;
    close_out();
  end
  ////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    // Reset values, unmapped slot, register A across a second reset
    foreach (RST_OFS[i]) rd(RST_OFS[i], 32'h0);
    rd(5'h1C, 32'h0, 32'hFFFFFFFF, RESP_SLVERR);
    wr(5'h1C, 32'hFF, RESP_SLVERR);
    wr(OFS_REG_A, 32'h5A);
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(OFS_REG_A, 32'h5A);
    $display("Test reset done");
    // Timer periods for every clock choice, two matches apart
    wr(OFS_IRQ_MASK, 32'h1);
    wr(OFS_REG_A, 32'h1);
    foreach (TCFG[i]) begin
      wr(OFS_CTRL, 32'h0);
      wr(OFS_IRQ_STAT, 32'h1);
      wr(OFS_CTRL, {24'h0, TCFG[i]});
      wait_irq(t1);
      wr(OFS_IRQ_STAT, 32'h1);
      wait_irq(t2);
      `CHK(t2 - t1, TPER[i])
    end
    wr(OFS_CTRL, 32'h0);
    rd(OFS_COUNT, 32'h0);
    $display("Test timer done");
    // Event counting of random pulses, then soft capture
    wr(OFS_REG_A, 32'hFF);
    wr(OFS_CTRL, 32'h3);
    lfsr = lfsr_next(lfsr);
    n = {29'h0, lfsr[2:0]} + 32'h1;
    repeat (n) begin
      lfsr = lfsr_next(lfsr);
      tmr8_src_inst.pulse(8 + lfsr[3:0], 8 + lfsr[7:4]);
    end
    rd(OFS_COUNT, n);
    wr(OFS_CTRL, 32'h43);
    rd(OFS_CTRL, 32'h3);
    rd(OFS_REG_B, n);
    // Falling edge selected: rise ignored, fall counted
    wr(OFS_CTRL, 32'h0);
    rd(OFS_COUNT, 32'h0);
    wr(OFS_EXT_CTRL, 32'h8);
    wr(OFS_CTRL, 32'h3);
    tmr8_src_inst.level(1'b1, 16);
    rd(OFS_COUNT, 32'h0);
    tmr8_src_inst.level(1'b0, 16);
    rd(OFS_COUNT, 32'h1);
    // Match in event mode, with the interrupt masked then unmasked
    wr(OFS_CTRL, 32'h0);
    wr(OFS_REG_A, 32'h2);
    wr(OFS_IRQ_MASK, 32'h0);
    wr(OFS_IRQ_STAT, 32'h1);
    wr(OFS_CTRL, 32'h3);
    repeat (3) tmr8_src_inst.pulse(10, 10);
    rd(OFS_COUNT, 32'h0);
    rd(OFS_IRQ_STAT, 32'h1);
    `CHK(timer_irq, 1'b0)
    wr(OFS_IRQ_MASK, 32'h1);
    repeat (2) @(posedge mclk);
    `CHK(timer_irq, 1'b1)
    wr(OFS_IRQ_STAT, 32'h1);
    repeat (2) @(posedge mclk);
    `CHK(timer_irq, 1'b0)
    $display("Test event done");
    // Capture: half-tick offsets make each count one of an even/odd pair
    wr(OFS_EXT_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h0);
    wr(OFS_CTRL, 32'h15);
    fork
      tmr8_src_inst.pulse(576, 768);
      begin
        repeat (30) @(posedge mclk);
        rd(OFS_REG_A, 32'h0, 32'h0);
        wr(OFS_IRQ_STAT, 32'h1);
      end
    join
    tmr8_src_inst.pulse(576, 2048);
    tmr8_src_inst.pulse(576, 768);
    rd(OFS_REG_B, 32'h4, 32'hFE);
    rd(OFS_REG_A, 32'hA, 32'hFE);
    rd(OFS_IRQ_STAT, 32'h1);
    // Overflow after re-arming, on a faster tick
    wr(OFS_IRQ_STAT, 32'h1);
    wr(OFS_CTRL, 32'h2D);
    wait_irq(t1);
    rd(OFS_REG_A, 32'hFF);
    $display("Test capture done");
    close_out();
  end
endmodule : tmr8_top_tb
